// ===== testbench/pdm_cpu_model.sv
// CPU core and interrupt source model
`default_nettype none
module pdm_cpu_model (
    input wire logic clk,
    output logic sleep_strobe,
    output logic watch_timer_select,
    output logic irq_request,
    output logic cpu_irq_mask
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Idle levels at time zero
    initial begin
        sleep_strobe = 1'b0;
        watch_timer_select = 1'b0;
        irq_request = 1'b0;
        cpu_irq_mask = 1'b0;
    end
    // One-cycle strobe of the sleep instruction
    task sleep;
        @(posedge clk);
        sleep_strobe <= 1'b1;
        @(posedge clk);
        sleep_strobe <= 1'b0;
    endtask
    // Interrupt request, mask and watch-timer levels
    task lv(input logic req, input logic mask, input logic wt);
        @(posedge clk);
        irq_request <= req;
        cpu_irq_mask <= mask;
        watch_timer_select <= wt;
    endtask
endmodule
`default_nettype wire

// ===== testbench/pdm_power_down_properties.sv
// Checker for the power-down mode controller ports
`default_nettype none
`include "pdm_defs.vh"
module pdm_power_down_properties (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic sleep_strobe,
    input wire logic irq_request,
    input wire logic cpu_irq_mask,
    input wire logic reset_pin_n,
    input wire logic [2:0] mode_q,
    input wire logic cpu_halt_q,
    input wire logic osc_stop_q,
    input wire logic cpu_reset_q,
    input wire logic exc_start_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] one_q;
    logic [7:0] two_q;
    wire logic wr = psel && penable && pready && pwrite;
    wire logic go = sleep_strobe && mode_q == `PDM_ACT_HI;
    // ==========================================
    // Shadow of the control bits, from APB writes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n || cpu_reset_q) begin
            one_q <= `PDM_RST_CTRL_ONE;
            two_q <= `PDM_RST_CTRL_TWO;
        end else if (wr && paddr == `PDM_OFS_CTRL_ONE) begin
            one_q <= pwdata[7:0];
        end else if (wr && paddr == `PDM_OFS_CTRL_TWO) begin
            two_q <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_read;
        psel && penable && pready && !pwrite;
    endsequence
    sequence s_wake;
        mode_q == `PDM_SLEEP_HI && irq_request && !cpu_irq_mask;
    endsequence
    chk_apb_ready: assert property (s_setup |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    chk_fixed_ones: assert property (s_read |->
        (paddr != `PDM_OFS_CTRL_ONE || prdata[2]) &&
        (paddr != `PDM_OFS_CTRL_TWO || &prdata[7:5]))
        else $error("fixed bits read zero");
    chk_halt_modes: assert property (cpu_halt_q == (mode_q >= 3) &&
        osc_stop_q == (mode_q >= 6)) else $error("halt flags wrong");
    chk_sleep_hi: assert property (go && one_q[7] == 0 &&
        one_q[3] == 0 && two_q[3:2] == 0 |=> mode_q == `PDM_SLEEP_HI)
        else $error("sleep high-speed not entered");
    chk_sleep_med: assert property (go && one_q[7] == 0 &&
        one_q[3] == 0 && two_q[3:2] == 2'b01 |=> mode_q == `PDM_SLEEP_MED)
        else $error("sleep medium-speed not entered");
    chk_direct_med: assert property (go && one_q[7] == 0 &&
        one_q[3] == 0 && two_q[3:2] == 2'b11 |=> mode_q == `PDM_ACT_MED)
        else $error("direct move to medium-speed missing");
    chk_irq_wake: assert property ((s_wake and reset_pin_n) |->
        ##[1:2] mode_q == `PDM_ACT_HI && exc_start_q)
        else $error("sleep not left on interrupt");
    chk_mask_holds: assert property (cpu_halt_q && cpu_irq_mask &&
        $past(cpu_irq_mask) && reset_pin_n |-> ##2 $stable(mode_q))
        else $error("masked interrupt woke the device");
    chk_pin_reset: assert property (!reset_pin_n [*4] |->
        cpu_reset_q && mode_q == `PDM_ACT_HI)
        else $error("reset pin did not reset");
endmodule
bind pdm_power_down_ctrl pdm_power_down_properties
    pdm_power_down_properties_inst (.*);
`default_nettype wire

// ===== testbench/test_power_down_mode_control.sv
// Self-checking bench for the power-down mode controller
`default_nettype none
`include "pdm_defs.vh"
module test_power_down_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic reset_pin_n = 1'b1;
    logic watch_clk = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, sleep_strobe, watch_timer_select;
    logic irq_request, cpu_irq_mask, cpu_halt_q, cpu_on_subclk_q;
    logic osc_stop_q, cpu_reset_q, exc_start_q, med_tick_q, sub_tick_q;
    logic [2:0] mode_q;
    int n_errors = 0;
    int compares = 0;
    pdm_power_down_ctrl pdm_power_down_ctrl_inst (.*);
    pdm_cpu_model pdm_cpu_model_inst (.*);
    // ==========================================
    // System clock and a watch clock of exactly 128 clk periods
    initial forever #4 clk = ~clk;
    initial forever #512 watch_clk = ~watch_clk;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // APB transfer, held until pready
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 20) begin
            chk(pready, 1'b1);
            end_sim;
        end
    endtask
    task rdk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask
    // Bounded wait for a mode, then compare
    task wm(input logic [2:0] exp);
        int i;
        #1;
        for (i = 0; i < 8 && mode_q !== exp; i++) begin
            @(posedge clk);
            #1;
        end
        chk(mode_q, exp);
        if (mode_q !== exp) end_sim;
    endtask
    task wake(input logic [2:0] exp);
        pdm_cpu_model_inst.lv(1'b1, 1'b0, watch_timer_select);
        wm(exp);
        chk(exc_start_q, 1'b1);
        pdm_cpu_model_inst.lv(1'b0, 1'b0, watch_timer_select);
    endtask
    task go(input logic [7:0] one, input logic [7:0] two);
        // Divider field only rewritten outside medium-speed mode
        if (mode_q !== `PDM_ACT_MED) begin
            apb(1'b1, `PDM_OFS_CTRL_ONE, one);
        end
        apb(1'b1, `PDM_OFS_CTRL_TWO, two);
        pdm_cpu_model_inst.sleep();
    endtask
    // Interval between medium-speed ticks
    task tick(input int per);
        int i, n;
        for (i = 0; i < 300 && med_tick_q !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (med_tick_q !== 1'b1 && n < 300);
        chk(n, per);
        if (n >= 300) end_sim;
    endtask
    // Interval between subactive ticks
    task stick(input int per);
        int i, n;
        for (i = 0; i < 1100 && sub_tick_q !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (sub_tick_q !== 1'b1 && n < 1100);
        chk(n, per);
        if (n >= 1100) end_sim;
    endtask
    task t_regs;
        rdk(`PDM_OFS_CTRL_ONE, 32'h0000_0007);
        rdk(`PDM_OFS_CTRL_TWO, 32'h0000_00F0);
        apb(1'b1, `PDM_OFS_CTRL_ONE, 8'h00);
        rdk(`PDM_OFS_CTRL_ONE, 32'h0000_0004);
        apb(1'b1, `PDM_OFS_CTRL_TWO, 8'h00);
        rdk(`PDM_OFS_CTRL_TWO, 32'h0000_00E0);
        rdk(12'h008, 32'h0000_0000);
        chk(er, 1'b1);
        $display("register test done");
    endtask
    task t_sleep;
        int m;
        for (m = 0; m < 2; m++) begin
            go(8'h00, m ? 8'h04 : 8'h00);
            wm(m ? `PDM_SLEEP_MED : `PDM_SLEEP_HI);
            chk(cpu_halt_q, 1'b1);
            pdm_cpu_model_inst.lv(1'b1, 1'b1, 1'b0);
            repeat (4) @(posedge clk);
            wm(m ? `PDM_SLEEP_MED : `PDM_SLEEP_HI);
            wake(m ? `PDM_ACT_MED : `PDM_ACT_HI);
        end
        go(8'h00, 8'h08);
        wm(`PDM_ACT_HI);
        $display("sleep test done");
    endtask
    task t_med;
        int c;
        for (c = 0; c < 4; c++) begin
            go(8'(c), 8'h0C);
            wm(`PDM_ACT_MED);
            tick(16 << c);
            go(8'(c), 8'h08);
            wm(`PDM_ACT_HI);
        end
        $display("medium-speed test done");
    endtask
    task t_sub;
        pdm_cpu_model_inst.lv(1'b0, 1'b0, 1'b1);
        go(8'h88, 8'h08);
        wm(`PDM_SUBACT);
        chk(cpu_on_subclk_q, 1'b1);
        apb(1'b1, `PDM_OFS_CTRL_TWO, 8'h0B);
        rdk(`PDM_OFS_CTRL_TWO, 32'h0000_00E8);
        go(8'h80, 8'h08);
        wm(`PDM_ACT_HI);
        go(8'h88, 8'h00);
        wm(`PDM_WATCH);
        wake(`PDM_SUBACT);
        go(8'h80, 8'h0C);
        wm(`PDM_ACT_MED);
        pdm_cpu_model_inst.lv(1'b0, 1'b0, 1'b0);
        go(8'h80, 8'h00);
        wm(`PDM_STANDBY);
        chk(osc_stop_q, 1'b1);
        wake(`PDM_ACT_HI);
        $display("subactive test done");
    endtask
    task t_pin;
        go(8'h00, 8'h00);
        wm(`PDM_SLEEP_HI);
        @(posedge clk);
        reset_pin_n <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk(cpu_reset_q, 1'b1);
        chk(mode_q, `PDM_ACT_HI);
        @(posedge clk);
        reset_pin_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk(cpu_reset_q, 1'b0);
        rdk(`PDM_OFS_CTRL_ONE, 32'h0000_0007);
        $display("reset pin test done");
    endtask
    task t_subdiv;
        int k;
        for (k = 0; k < 4; k++) begin
            apb(1'b1, `PDM_OFS_CTRL_TWO, 8'(k));
            stick(k > 1 ? 256 : 1024 >> k);
        end
        $display("subactive divider test done");
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        t_regs;
        t_sleep;
        t_med;
        t_sub;
        t_pin;
        t_subdiv;
        end_sim;
    end
endmodule
`default_nettype wire

// ===== verilog/pdm_defs.vh
// Constants for the power-down mode controller
`ifndef PDM_DEFS_VH
`define PDM_DEFS_VH

// ==========================================================
// Register map, word aligned byte addresses
`define PDM_ADDR_W 12
`define PDM_OFS_CTRL_ONE 12'h000
`define PDM_OFS_CTRL_TWO 12'h004

// ==========================================================
// Reset values
`define PDM_RST_CTRL_ONE 8'h07
`define PDM_RST_CTRL_TWO 8'hF0

// ==========================================================
// Field positions, control register one
`define PDM_B_SW_STANDBY 7
`define PDM_B_WAKE_CLK 3
`define PDM_B_ONE_FIXED 2
`define PDM_B_MED_DIV_HI 1
`define PDM_B_MED_DIV_LO 0
// Bits that always read one
`define PDM_FIXED_ONE 8'h04
`define PDM_FIXED_TWO 8'hE0

// ==========================================================
// Field positions, control register two
`define PDM_B_NOISE_SEL 4
`define PDM_B_DIRECT 3
`define PDM_B_MED_SEL 2
`define PDM_B_SUB_DIV_HI 1
`define PDM_B_SUB_DIV_LO 0

// ==========================================================
// Mode codes
`define PDM_MODE_W 3
`define PDM_ACT_HI 3'h0
`define PDM_ACT_MED 3'h1
`define PDM_SUBACT 3'h2
`define PDM_SLEEP_HI 3'h3
`define PDM_SLEEP_MED 3'h4
`define PDM_SUBSLEEP 3'h5
`define PDM_STANDBY 3'h6
`define PDM_WATCH 3'h7

// ==========================================================
// Divider terminal counts (cycles minus one)
`define PDM_MED_DIV16 7'h0F
`define PDM_MED_DIV32 7'h1F
`define PDM_MED_DIV64 7'h3F
`define PDM_MED_DIV128 7'h7F
`define PDM_NS_DIV16 4'hF
`define PDM_NS_DIV4 2'h3
`define PDM_SUB_DIV8 3'h7
`define PDM_SUB_DIV4 3'h3
`define PDM_SUB_DIV2 3'h1

`endif

// ===== verilog/pdm_power_down_ctrl.v
// Power-down mode controller with APB register access
`default_nettype none
`include "pdm_defs.vh"

module pdm_power_down_ctrl (
    input wire clk,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire sleep_strobe,
    input wire watch_timer_select,
    input wire irq_request,
    input wire cpu_irq_mask,
    input wire reset_pin_n,
    input wire watch_clk,
    output reg [2:0] mode_q,
    output reg cpu_halt_q,
    output reg cpu_on_subclk_q,
    output reg osc_stop_q,
    output reg cpu_reset_q,
    output reg exc_start_q,
    output reg med_tick_q,
    output reg sub_tick_q
);

    // ==========================================================
    // Declarations
    reg [7:0] ctrl_one_q;
    reg [7:0] ctrl_two_q;
    reg rst_s1_q;
    reg rst_s2_q;
    reg wclk_s1_q;
    reg wclk_s2_q;
    reg wclk_smp_q;
    reg wclk_prev_q;
    reg irq_q;
    reg [6:0] med_cnt_q;
    reg [3:0] ns_cnt_q;
    reg [2:0] sub_cnt_q;
    reg [2:0] mode_d;
    reg wake_d;
    reg [6:0] med_top;
    reg [2:0] sub_top;
    reg [31:0] rdata_d;
    reg err_d;
    wire sw_standby;
    wire wake_clk;
    wire noise_sel;
    wire direct;
    wire med_sel;
    wire setup;
    wire wr_en;
    wire sel_one;
    wire sel_two;
    wire ns_tick;
    wire wclk_rise;
    wire in_medium;

    // Control bit aliases
    assign sw_standby = ctrl_one_q[`PDM_B_SW_STANDBY];
    assign wake_clk = ctrl_one_q[`PDM_B_WAKE_CLK];
    assign noise_sel = ctrl_two_q[`PDM_B_NOISE_SEL];
    assign direct = ctrl_two_q[`PDM_B_DIRECT];
    assign med_sel = ctrl_two_q[`PDM_B_MED_SEL];

    // Bus decode
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready & pwrite;
    assign sel_one = (paddr == `PDM_OFS_CTRL_ONE);
    assign sel_two = (paddr == `PDM_OFS_CTRL_TWO);

    // ==========================================================
    // Pin synchronisers
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= 1'b1;
            wclk_s1_q <= 1'b0;
            wclk_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= reset_pin_n;
            rst_s2_q <= rst_s1_q;
            wclk_s1_q <= watch_clk;
            wclk_s2_q <= wclk_s1_q;
        end
    end

    // ==========================================================
    // Read data and error for the access phase
    always @* begin
        rdata_d = 32'h0000_0000;
        err_d = 1'b0;
        if (sel_one) begin
            rdata_d[7:0] = ctrl_one_q | `PDM_FIXED_ONE;
        end else if (sel_two) begin
            rdata_d[7:0] = ctrl_two_q | `PDM_FIXED_TWO;
        end else begin
            err_d = 1'b1;
        end
    end

    // APB answer, registered in setup, zero wait states
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup & err_d;
            if (setup && !pwrite) begin
                prdata <= rdata_d;
            end
        end
    end

    // ==========================================================
    // Control registers
    // Divider field is not gated by mode; software keeps to it
    // Noise select frequency range is software's duty
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_one_q <= `PDM_RST_CTRL_ONE;
            ctrl_two_q <= `PDM_RST_CTRL_TWO;
        end else if (!rst_s2_q) begin
            ctrl_one_q <= `PDM_RST_CTRL_ONE;
            ctrl_two_q <= `PDM_RST_CTRL_TWO;
        end else if (wr_en && sel_one) begin
            ctrl_one_q <= pwdata[7:0] | `PDM_FIXED_ONE;
        end else if (wr_en && sel_two) begin
            ctrl_two_q[7:2] <= pwdata[7:2] | 6'h38;
            if (mode_q != `PDM_SUBACT) begin
                ctrl_two_q[1:0] <= pwdata[1:0];
            end
        end
    end

    // ==========================================================
    // Interrupt synchroniser stage, one cycle of delay
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_request & ~cpu_irq_mask;
        end
    end

    // ==========================================================
    // Next mode selection
    always @* begin
        mode_d = mode_q;
        wake_d = 1'b0;
        case (mode_q)
            `PDM_ACT_HI, `PDM_ACT_MED: begin
                if (sleep_strobe) begin
                    if (direct) begin
                        if (sw_standby && watch_timer_select
                            && wake_clk) begin
                            mode_d = `PDM_SUBACT;
                        end else if (!sw_standby && !wake_clk
                            && mode_q == `PDM_ACT_HI && med_sel) begin
                            mode_d = `PDM_ACT_MED;
                        end else if (!sw_standby && !wake_clk
                            && mode_q == `PDM_ACT_MED && !med_sel) begin
                            mode_d = `PDM_ACT_HI;
                        end
                    end else if (!sw_standby) begin
                        // Sleep mode: medium-speed when med_sel is set, else high-speed
                        mode_d = med_sel ? `PDM_SLEEP_MED
                            : `PDM_SLEEP_HI;
                    end else if (watch_timer_select) begin
                        mode_d = `PDM_WATCH;
                    end else if (!wake_clk) begin
                        mode_d = `PDM_STANDBY;
                    end
                end
            end
            `PDM_SUBACT: begin
                if (sleep_strobe) begin
                    if (direct && sw_standby && watch_timer_select
                        && !wake_clk) begin
                        mode_d = med_sel ? `PDM_ACT_MED
                            : `PDM_ACT_HI;
                    end else if (!sw_standby) begin
                        mode_d = `PDM_SUBSLEEP;
                    end else if (watch_timer_select) begin
                        mode_d = `PDM_WATCH;
                    end
                end
            end
            `PDM_SLEEP_HI: begin
                if (irq_q) begin
                    mode_d = `PDM_ACT_HI;
                    wake_d = 1'b1;
                end
            end
            `PDM_SLEEP_MED: begin
                if (irq_q) begin
                    mode_d = `PDM_ACT_MED;
                    wake_d = 1'b1;
                end
            end
            `PDM_STANDBY: begin
                if (irq_q) begin
                    mode_d = med_sel ? `PDM_ACT_MED
                        : `PDM_ACT_HI;
                    wake_d = 1'b1;
                end
            end
            `PDM_WATCH: begin
                if (irq_q) begin
                    if (wake_clk) begin
                        mode_d = `PDM_SUBACT;
                    end else begin
                        mode_d = med_sel ? `PDM_ACT_MED
                            : `PDM_ACT_HI;
                    end
                    wake_d = 1'b1;
                end
            end
            `PDM_SUBSLEEP: begin
                if (irq_q) begin
                    mode_d = `PDM_SUBACT;
                    wake_d = 1'b1;
                end
            end
            default: begin
                mode_d = `PDM_ACT_HI;
            end
        endcase
    end

    // ==========================================================
    // Mode register and decoded mode outputs
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= `PDM_ACT_HI;
            cpu_halt_q <= 1'b0;
            cpu_on_subclk_q <= 1'b0;
            osc_stop_q <= 1'b0;
            cpu_reset_q <= 1'b1;
            exc_start_q <= 1'b0;
        end else if (!rst_s2_q) begin
            mode_q <= `PDM_ACT_HI;
            cpu_halt_q <= 1'b0;
            cpu_on_subclk_q <= 1'b0;
            osc_stop_q <= 1'b0;
            cpu_reset_q <= 1'b1;
            exc_start_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            cpu_halt_q <= (mode_d != `PDM_ACT_HI)
                && (mode_d != `PDM_ACT_MED)
                && (mode_d != `PDM_SUBACT);
            cpu_on_subclk_q <= (mode_d == `PDM_SUBACT)
                || (mode_d == `PDM_SUBSLEEP);
            osc_stop_q <= (mode_d == `PDM_STANDBY)
                || (mode_d == `PDM_WATCH);
            cpu_reset_q <= 1'b0;
            exc_start_q <= wake_d;
        end
    end

    // ==========================================================
    // Medium-speed clock divider
    assign in_medium = (mode_q == `PDM_ACT_MED)
        || (mode_q == `PDM_SLEEP_MED);

    // Terminal count from divider code
    always @* begin
        case (ctrl_one_q[1:0])
            2'b00: med_top = `PDM_MED_DIV16;
            2'b01: med_top = `PDM_MED_DIV32;
            2'b10: med_top = `PDM_MED_DIV64;
            default: med_top = `PDM_MED_DIV128;
        endcase
    end

    // Counter and tick, runs only in medium-speed modes
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            med_cnt_q <= 7'h00;
            med_tick_q <= 1'b0;
        end else if (!in_medium || med_cnt_q >= med_top) begin
            med_cnt_q <= 7'h00;
            med_tick_q <= in_medium;
        end else begin
            med_cnt_q <= med_cnt_q + 7'h01;
            med_tick_q <= 1'b0;
        end
    end

    // ==========================================================
    // Watch clock noise sampling
    assign ns_tick = noise_sel ? (ns_cnt_q[1:0] == `PDM_NS_DIV4)
        : (ns_cnt_q == `PDM_NS_DIV16);
    assign wclk_rise = wclk_smp_q & ~wclk_prev_q;

    // Sample counter and sampled watch clock
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ns_cnt_q <= 4'h0;
            wclk_smp_q <= 1'b0;
            wclk_prev_q <= 1'b0;
        end else begin
            ns_cnt_q <= ns_cnt_q + 4'h1;
            wclk_prev_q <= wclk_smp_q;
            if (ns_tick) begin
                wclk_smp_q <= wclk_s2_q;
            end
        end
    end

    // ==========================================================
    // Subactive clock divider on sampled watch clock edges
    always @* begin
        case (ctrl_two_q[1:0])
            2'b00: sub_top = `PDM_SUB_DIV8;
            2'b01: sub_top = `PDM_SUB_DIV4;
            default: sub_top = `PDM_SUB_DIV2;
        endcase
    end

    // Counter and tick, one pulse per selected watch clock count
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sub_cnt_q <= 3'h0;
            sub_tick_q <= 1'b0;
        end else if (wclk_rise && sub_cnt_q >= sub_top) begin
            sub_cnt_q <= 3'h0;
            sub_tick_q <= 1'b1;
        end else if (wclk_rise) begin
            sub_cnt_q <= sub_cnt_q + 3'h1;
            sub_tick_q <= 1'b0;
        end else begin
            sub_tick_q <= 1'b0;
        end
    end

endmodule
`default_nettype wire
